// ---- verilog/rlyasg_regs.vh ----
// register offsets, bitmap field positions and mode encodings for the relay assignment block
`ifndef RLYASG_REGS_VH
`define RLYASG_REGS_VH
`define RLYASG_ADDR_W 16
`define RLYASG_DATA_W 32
`define RLYASG_MAIN_MAP_ADDR 16'h0BE4
`define RLYASG_PREV_MAP_ADDR 16'h0BE6
`define RLYASG_BIT_PREV 0
`define RLYASG_BIT_INS 4
`define RLYASG_BIT_INH 8
`define RLYASG_BIT_SYS 16
`define RLYASG_BIT_PROD 24
`define RLYASG_VALID_MASK 32'h01010111
`define RLYASG_MAIN_RESET 32'h01010010
`define RLYASG_PREV_RESET 32'h01010000
`define RLYASG_ZERO 32'h00000000
`define RLYASG_MODE_FS 2'h0
`define RLYASG_MODE_STD 2'h1
`define RLYASG_MODE_MIRROR 2'h2
`define RLYASG_INH_NO 2'h0
`define RLYASG_INH_NC 2'h1
`define RLYASG_INH_OFF 2'h2
`endif

// ---- verilog/rlyasg_drive.v ----
// one relay: or over assigned conditions, then energize polarity by mode
`timescale 1ns/1ps
`default_nettype none
`include "rlyasg_regs.vh"
module rlyasg_drive (
  input wire [31:0] map,
  input wire [31:0] cond,
  input wire failsafe,
  output wire alarm,
  output wire coil
);
  // ------------------------------------------------------------
  // alarm and coil
  // ------------------------------------------------------------
  assign alarm = |(map & cond & `RLYASG_VALID_MASK);
  // failsafe keeps the coil energized while healthy, so a dead unit reads as alarm
  assign coil = failsafe ? ~alarm : alarm;
endmodule
`default_nettype wire

// ---- verilog/rlyasg_top.v ----
// relay assignment bitmaps, relay drive and injection inhibit input handling
`timescale 1ns/1ps
`default_nettype none
`include "rlyasg_regs.vh"
//
// Function
// - assignments change through the serial bus, the threshold and inhibit ack settings and mirror mode
// - main map 3044, preventive map 3046
// - bits 0,4,8,16,24 used, rest reserved
// - preventive map bit 0 is read-only
// - main map bit 4 is read-only
// - self-test fail product, wiring faults system
// - main map reset: insulation, product, system
// - preventive map reset: product and system
// - preventive threshold on sets preventive bit
// - mirror mode clears and locks preventive map
// - inhibit ack off clears, refuses inhibit bit
// - inhibit ack on sets main inhibit bit
// - inhibit input normally-open, normally-closed or off
// - input off ignored, bus exclusion still works
// - mirror follows main relay while operating
module rlyasg_top (
  input wire clock,
  input wire rst,
  input wire bus_wr,
  input wire bus_rd,
  input wire [15:0] bus_addr,
  input wire [31:0] bus_wdata,
  output reg [31:0] bus_rdata,
  output reg bus_ack,
  output reg bus_err,
  input wire [1:0] preventive_relay_mode,
  input wire [1:0] main_relay_mode,
  input wire [1:0] inhibit_input_mode,
  input wire inhibit_ack_on,
  input wire prev_threshold_on,
  input wire bus_inhibit,
  input wire inhibit_contact_closed,
  input wire preventive_fault,
  input wire insulation_fault,
  input wire selftest_failed,
  input wire injection_disconnected,
  input wire over_voltage,
  input wire over_capacitance,
  input wire operative,
  output reg [31:0] main_map,
  output reg [31:0] prev_map,
  output reg main_alarm_relay,
  output reg preventive_relay,
  output reg inject_enable,
  output reg injection_inhibited
);
  // ------------------------------------------------------------
  // condition vector
  // ------------------------------------------------------------
  reg contact_inhibit;
  reg [31:0] cond;
  reg inh_ack_d;
  wire prod_err;
  wire sys_err;
  wire main_sel;
  wire prev_sel;
  wire main_coil;
  wire prev_coil;
  wire mirror;
  wire main_hit;
  wire prev_hit;
  reg [31:0] next_main;
  reg [31:0] next_prev;
  reg next_inhibited;

  assign prod_err = selftest_failed;
  assign sys_err = injection_disconnected | over_voltage | over_capacitance;
  assign mirror = (preventive_relay_mode == `RLYASG_MODE_MIRROR);

  always @* begin
    case (inhibit_input_mode)
      `RLYASG_INH_NO: contact_inhibit = inhibit_contact_closed;
      `RLYASG_INH_NC: contact_inhibit = ~inhibit_contact_closed;
      default: contact_inhibit = 1'b0;
    endcase
    // bus exclusion stays active whatever the contact setting
    next_inhibited = contact_inhibit | bus_inhibit;
    cond = `RLYASG_ZERO;
    cond[`RLYASG_BIT_PREV] = preventive_fault;
    cond[`RLYASG_BIT_INS] = insulation_fault;
    cond[`RLYASG_BIT_INH] = injection_inhibited;
    cond[`RLYASG_BIT_SYS] = sys_err;
    cond[`RLYASG_BIT_PROD] = prod_err;
  end

  // ------------------------------------------------------------
  // register bus decode
  // ------------------------------------------------------------
  // the serial bus port writes the maps; threshold, inhibit ack and mirror mode also update them
  assign main_hit = (bus_addr == `RLYASG_MAIN_MAP_ADDR);
  assign prev_hit = (bus_addr == `RLYASG_PREV_MAP_ADDR);
  assign main_sel = bus_wr & main_hit;
  assign prev_sel = bus_wr & prev_hit & ~mirror;

  always @* begin
    next_main = main_map;
    next_prev = prev_map;
    if (main_sel) begin
      next_main = bus_wdata & `RLYASG_VALID_MASK;
      next_main[`RLYASG_BIT_INS] = main_map[`RLYASG_BIT_INS];
    end
    if (prev_sel) begin
      next_prev = bus_wdata & `RLYASG_VALID_MASK;
      next_prev[`RLYASG_BIT_PREV] = prev_map[`RLYASG_BIT_PREV];
    end
    // preventive bit in the preventive map tracks the threshold setting
    next_prev[`RLYASG_BIT_PREV] = prev_threshold_on;
    if (inhibit_ack_on & ~inh_ack_d) begin
      next_main[`RLYASG_BIT_INH] = 1'b1;
    end
    if (~inhibit_ack_on) begin
      next_main[`RLYASG_BIT_INH] = 1'b0;
      next_prev[`RLYASG_BIT_INH] = 1'b0;
    end
    if (mirror) begin
      next_prev = `RLYASG_ZERO;
    end
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      main_map <= `RLYASG_MAIN_RESET;
      prev_map <= `RLYASG_PREV_RESET;
      inh_ack_d <= 1'b0;
      bus_rdata <= `RLYASG_ZERO;
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      main_alarm_relay <= 1'b0;
      preventive_relay <= 1'b0;
      inject_enable <= 1'b0;
      injection_inhibited <= 1'b0;
    end else begin
      main_map <= next_main;
      prev_map <= next_prev;
      inh_ack_d <= inhibit_ack_on;
      bus_ack <= (bus_wr | bus_rd) & (main_hit | prev_hit);
      // unmapped access and a refused write to a locked map both flag an error
      bus_err <= ((bus_wr | bus_rd) & ~(main_hit | prev_hit)) | (bus_wr & prev_hit & mirror);
      if (bus_rd & main_hit) begin
        bus_rdata <= main_map;
      end else if (bus_rd & prev_hit) begin
        bus_rdata <= prev_map;
      end else begin
        bus_rdata <= `RLYASG_ZERO;
      end
      injection_inhibited <= next_inhibited;
      inject_enable <= ~next_inhibited;
      main_alarm_relay <= operative & main_coil;
      // mirror copies the main coil only while the unit is operating
      preventive_relay <= operative & (mirror ? main_coil : prev_coil);
    end
  end

  // ------------------------------------------------------------
  // relay drivers
  // ------------------------------------------------------------
  rlyasg_drive u_main (
    .map(main_map),
    .cond(cond),
    .failsafe(main_relay_mode == `RLYASG_MODE_FS),
    .alarm(),
    .coil(main_coil)
  );

  rlyasg_drive u_prev (
    .map(prev_map),
    .cond(cond),
    .failsafe(preventive_relay_mode == `RLYASG_MODE_FS),
    .alarm(),
    .coil(prev_coil)
  );
endmodule
`default_nettype wire

// ---- testbench/rlyasg_properties.sv ----
// port-level assertions for the relay assignment block
`timescale 1ns/1ps
`default_nettype none
module rlyasg_properties (
  input wire clock, rst, bus_wr, bus_rd, bus_ack, bus_err, inhibit_ack_on, operative,
  input wire main_alarm_relay, preventive_relay,
  input wire [15:0] bus_addr,
  input wire [1:0] preventive_relay_mode,
  input wire [31:0] main_map, prev_map
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire mirror = preventive_relay_mode == 2'h2;
  a_write_ack: assert property (bus_wr && bus_addr == 16'h0BE4 |=> bus_ack) else $error("no ack");
  a_unmapped_err: assert property ((bus_wr || bus_rd) && !(bus_addr inside {16'h0BE4, 16'h0BE6}) |=> bus_err)
    else $error("no err");
  a_ins_bit_ro: assert property (main_map[4]) else $error("bit 4");
  a_mirror_clear: assert property (mirror |=> !prev_map) else $error("map set");
  a_inh_bit_off: assert property (!inhibit_ack_on |=> !main_map[8] && !prev_map[8]) else $error("bit 8");
  a_ack_sets_bit: assert property ($rose(inhibit_ack_on) |=> main_map[8]) else $error("no bit 8");
  a_mirror_follow: assert property (mirror |=> preventive_relay == main_alarm_relay) else $error("mirror");
  a_dead_off: assert property (!operative |=> !main_alarm_relay && !preventive_relay) else $error("dead");
endmodule
bind rlyasg_top rlyasg_properties chk_u (.*);
`default_nettype wire

// ---- testbench/rlyasg_plc.sv ----
// contact reader on the far side of the two relays
`timescale 1ns/1ps
`default_nettype none
module rlyasg_plc (
  input wire in1,
  input wire in2,
  input wire brk1,
  input wire brk2,
  output wire alarm,
  output wire failure,
  output wire series_nc,
  output wire inhibit_second
);
  assign alarm = in1 & in2;
  assign failure = !in1;
  // closed contacts of both de-energized coils in series
  assign series_nc = !in1 & !in2;
  // breaker auxiliaries: second unit stops injecting with both feeders closed
  assign inhibit_second = brk1 & brk2;
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the relay assignment block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] ma = 16'h0BE4, pa = 16'h0BE6;
  logic clock = 0, rst = 1, bus_wr = 0, bus_rd = 0, inhibit_ack_on = 0, prev_threshold_on = 0, bus_inhibit = 0;
  logic inhibit_contact_closed = 0, operative = 1, preventive_fault = 0, insulation_fault = 0, selftest_failed = 0;
  logic injection_disconnected = 0, over_voltage = 0, over_capacitance = 0, bus_ack, bus_err, main_alarm_relay;
  logic preventive_relay, inject_enable, injection_inhibited, brk1 = 0, brk2 = 0;
  wire plc_alarm, plc_fail, plc_series, feed_inh;
  logic [1:0] preventive_relay_mode = 0, main_relay_mode = 0, inhibit_input_mode = 0;
  logic [15:0] bus_addr = 0;
  logic [31:0] bus_wdata = 0, bus_rdata, main_map, prev_map;
  int err_total = 0, samples_checked = 0, mm = 32'h01010011, pm = 32'h101, r, c, inh, am, ap, cm, pe;
  rlyasg_top dut_u (.*);
  rlyasg_plc plc_u (.in1(main_alarm_relay), .in2(preventive_relay), .brk1(brk1), .brk2(brk2), .alarm(plc_alarm),
    .failure(plc_fail), .series_nc(plc_series), .inhibit_second(feed_inh));
  initial forever #50 clock = ~clock;
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    err_total += (s !== e);
    if (s !== e) $display("BAD %s exp %h got %h", n, e, s);
  endtask
  // v is write data, or the expected word on a read
  task acc(input logic w, input logic [15:0] a, input logic [31:0] v, input logic [1:0] e = 1);
    @(posedge clock);
    {bus_wr, bus_rd, bus_addr, bus_wdata} <= {w, !w, a, v};
    @(posedge clock);
    {bus_wr, bus_rd} <= 2'b0;
    #1 chk("resp", {bus_err, bus_ack}, e);
    if (!w) chk("rdata", bus_rdata, v);
  endtask
  initial begin
    #200us err_total++;
    end_sim;
  end
  initial begin
    void'($urandom(6));
    repeat (20) @(posedge clock);
    rst <= 0;
    acc(0, ma, 32'h01010010);
    acc(0, pa, 32'h01010000);
    acc(1, ma, '1);
    acc(0, ma, 32'h01010011);
    acc(1, pa, '1);
    acc(0, pa, 32'h01010010);
    acc(0, 16'h0BE5, 0, 2);
    @(posedge clock);
    preventive_relay_mode <= 2;
    acc(1, pa, '1, 3);
    acc(0, pa, 0);
    @(posedge clock);
    {preventive_relay_mode, prev_threshold_on, inhibit_ack_on} <= 4'b0111;
    acc(0, pa, 1);
    acc(0, ma, 32'h01010111);
    acc(1, pa, 32'h100);
    acc(1, ma, 32'h01010011);
    acc(0, pa, 32'h101);
    // settle three cycles: inhibit then relay are each one register deep
    repeat (40) begin
      @(posedge clock);
      r = $urandom;
      {preventive_fault, insulation_fault, selftest_failed, injection_disconnected, over_voltage, over_capacitance,
        bus_inhibit, inhibit_contact_closed, operative, inhibit_input_mode, main_relay_mode, preventive_relay_mode} <= r[14:0];
      pm = r[1:0] == 2 ? 0 : pm | 1;
      inh = r[8] | (r[5:4] == 0 & r[7]) | (r[5:4] == 1 & !r[7]);
      c = r[14] | r[13] << 4 | inh << 8 | (r[11] | r[10] | r[9]) << 16 | r[12] << 24;
      am = (mm & c) != 0;
      ap = (pm & c) != 0;
      cm = r[6] & (r[3:2] ? am : !am);
      pe = r[1:0] == 2 ? cm : r[6] & (r[1:0] ? ap : !ap);
      repeat (3) @(posedge clock);
      #1 chk("inject", inject_enable, !inh);
      chk("main", main_alarm_relay, cm);
      chk("prev", preventive_relay, pe);
      chk("plc_alarm", plc_alarm, cm & pe);
      chk("plc_fail", plc_fail, !cm);
      chk("plc_series", plc_series, !cm & !pe);
    end
    // feeder breakers drive the contact in normally-open setting
    repeat (8) begin
      @(posedge clock);
      r = $urandom;
      {brk1, brk2} <= r[1:0];
      @(posedge clock);
      {inhibit_contact_closed, bus_inhibit, inhibit_input_mode} <= {feed_inh, 1'b0, 2'h0};
      repeat (2) @(posedge clock);
      #1 chk("feeder", inject_enable, !(r[1] & r[0]));
    end
    end_sim;
  end
endmodule
`default_nettype wire
